// File: playback_pkg.sv
// shared constants for the playback volume, de-emphasis and soft mute block
package playback_pkg;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;   // control bits
  localparam logic [3:0]  ADDR_LEFT     = 4'h1;   // left volume code
  localparam logic [3:0]  ADDR_RIGHT    = 4'h2;   // right volume code
  localparam logic [3:0]  ADDR_STATUS   = 4'h3;   // ramp state, read only

  // control register field positions
  localparam int          CTRL_DEEMPH_LSB = 0;    // two bits
  localparam int          CTRL_BOOST_LSB  = 2;    // two bits
  localparam int          CTRL_GANG_BIT   = 4;
  localparam int          CTRL_RAMP_BIT   = 5;
  localparam int          CTRL_SOFT_MUTE_REQUEST_BIT  = 6;

  // status register field positions
  localparam int          STAT_BUSY_BIT   = 0;    // a ramp is still moving
  localparam int          STAT_MUTED_BIT  = 1;    // both channels at zero gain

  // reset values
  localparam logic [1:0]  DEEMPH_RESET  = 2'h1;   // filter off
  localparam logic [1:0]  BOOST_RESET   = 2'h0;   // boost off
  localparam logic [7:0]  VOLUME_RESET  = 8'h18;  // 0 dB

  // ==========================================================================
  // de-emphasis selector codes and filter coefficients (Q14, index = code)
  // ==========================================================================
  localparam logic [1:0]  DEEMPH_44K1   = 2'h0;
  localparam logic [1:0]  DEEMPH_OFF    = 2'h1;
  localparam logic [1:0]  DEEMPH_48K    = 2'h2;
  localparam logic [1:0]  DEEMPH_32K    = 2'h3;
  localparam int          COEF_FRAC     = 14;
  // order of elements: {32k, 48k, off, 44.1k}; zero at 15 us, pole at 50 us
  localparam logic [3:0][15:0] DEEMPH_B0 = {16'h21F9, 16'h1D0E, 16'h4000, 16'h1DEF};
  localparam logic [3:0][15:0] DEEMPH_B1 = {16'hFBC5, 16'hF8C1, 16'h0000, 16'hF967};
  localparam logic [3:0][15:0] DEEMPH_A1 = {16'h2242, 16'h2A30, 16'h0000, 16'h28AA};

  // ==========================================================================
  // bass boost
  // ==========================================================================
  localparam logic [1:0]  BOOST_OFF     = 2'h0;
  localparam logic [1:0]  BOOST_MIN     = 2'h1;
  localparam logic [1:0]  BOOST_MID     = 2'h2;
  localparam logic [1:0]  BOOST_MAX     = 2'h3;
  localparam int          BOOST_SHIFT   = 6;      // low-pass smoothing shift

  // ==========================================================================
  // volume and ramp: one level is 0.125 dB, level 0 is +12 dB
  // ==========================================================================
  localparam logic [7:0]  VOLUME_MUTE     = 8'hFF;
  localparam int          LEVEL_PER_CODE  = 2;     // shift: four levels per code
  localparam logic [10:0] LEVEL_MUTE      = 11'h425; // 1061, last of 1062 levels
  localparam logic [10:0] STEP_SLOW       = 11'h001;
  localparam logic [10:0] STEP_FAST       = 11'h004;
  localparam logic [10:0] LEVELS_PER_OCT  = 11'h030; // 48 levels halve the gain
  localparam int          GAIN_FRAC       = 15;
  localparam int          VOL_SHIFT       = 13;    // gain 1.0 at level 0 means x4
  // gain of 2^(-k/6), k = 0..5, and 2^(-j/48), j = 0..7, in Q15
  localparam logic [5:0][15:0] GAIN_COARSE = {16'h47D6, 16'h50A3, 16'h5A82,
                                              16'h6598, 16'h7209, 16'h8000};
  localparam logic [7:0][15:0] GAIN_FINE   = {16'h73B1, 16'h7560, 16'h7715, 16'h78D1,
                                              16'h7A93, 16'h7C5B, 16'h7E2A, 16'h8000};

endpackage

// File: sample_fifo.sv
// flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps

module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,   // writer offers a word
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,   // registered, low while full
  output logic                  out_valid,  // a word is waiting
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready   // reader takes the word
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;       // storage
    logic [AW-1:0]               wr_ptr;    // next slot to fill
    logic [AW-1:0]               rd_ptr;    // oldest word
    logic [AW:0]                 count;     // words held
    logic                        not_full;  // registered ready
  } fifo_s;

  fifo_s cur;
  fifo_s next_cur;

  logic push;
  logic pop;

  assign push      = in_valid & cur.not_full;
  assign pop       = out_ready & (cur.count != '0);
  assign in_ready  = cur.not_full;
  assign out_valid = (cur.count != '0);
  assign out_data  = cur.mem[cur.rd_ptr];

  // ==========================================================================
  // pointer and count update
  // ==========================================================================
  // pointers wrap by index compare so any depth works, not only powers of two
  always_comb begin
    next_cur = cur;
    if (push) begin
      next_cur.mem[cur.wr_ptr] = in_data;
      next_cur.wr_ptr = (cur.wr_ptr == AW'(DEPTH - 1)) ? '0 : cur.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_cur.rd_ptr = (cur.rd_ptr == AW'(DEPTH - 1)) ? '0 : cur.rd_ptr + 1'b1;
    end
    next_cur.count = cur.count + (AW+1)'(push) - (AW+1)'(pop);
    next_cur.not_full = (next_cur.count < (AW+1)'(DEPTH));
  end

  // state register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
      cur.not_full <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

endmodule

// File: playback_volume.sv
// playback path: de-emphasis, bass boost, ramped stereo volume and soft mute
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/100ps
//
// Summary of operation
// - de-emphasis is a first order IIR filter
// - selector: 00 44.1k, 01 off, 10 48k, 11 32k
// - boost selector: off, minimum, medium, maximum
// - boosted overflow saturates at full scale
// - 256 volume codes of 0.5 dB, per channel
// - 00H +12 dB, 18H 0 dB, FFH mute
// - volume scales samples before the DAC
// - gang set: left code drives both channels
// - gang clear: each channel uses own code
// - ramp slow 1061/fs or fast 266/fs
// - slow ramp walks 1062 gain levels
// - soft mute ramps output down to zero
// - mute release ramps back to programmed volume
// - early release reverses ramp from current level

module playback_volume #(
  parameter int SAMPLE_W   = 16,
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic                         sys_clk,
  input  wire logic                         reset_n,
  // register port
  input  wire logic [playback_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_write,
  input  wire logic                         reg_read,
  output logic [7:0]                        reg_rdata,
  // samples from the serial audio interface
  input  wire logic                         sample_valid,
  input  wire logic [SAMPLE_W-1:0]          sample_left,
  input  wire logic [SAMPLE_W-1:0]          sample_right,
  output logic                              sample_ready,
  // samples toward the DAC
  output logic                              dac_valid,
  output logic [SAMPLE_W-1:0]               dac_left,
  output logic [SAMPLE_W-1:0]               dac_right,
  input  wire logic                         dac_ready
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [1:0]                  deemph_select;
    logic [1:0]                  boost_select;
    logic                        volume_gang;
    logic                        ramp_time_select;
    logic                        soft_mute_request;
    logic [7:0]                  left_volume_code;
    logic [7:0]                  right_volume_code;
    logic [7:0]                  rd_data;     // read answer, one cycle only
    logic [1:0][10:0]            level;       // present ramp level per channel
    logic [1:0][SAMPLE_W-1:0]    x1;          // previous filter input
    logic [1:0][SAMPLE_W-1:0]    y1;          // previous filter output
    logic [1:0][SAMPLE_W-1:0]    lp;          // bass low-pass state
    logic [1:0][SAMPLE_W-1:0]    dac;         // output sample held for the DAC
    logic                        dac_valid;
  } play_s;

  play_s cur;
  play_s next_cur;

  // fifo wiring: left in the upper half of each word
  logic                    fifo_valid;   // stereo pair waiting
  logic [2*SAMPLE_W-1:0]   fifo_data;
  logic                    take;         // pair consumed this cycle
  logic [1:0][10:0]        target;       // level the ramp is heading to
  logic                    busy;         // ramp not yet at target

  // the fifo absorbs bursts from the serial side; its ready is our ready
  sample_fifo #(
    .WIDTH (2*SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (sample_valid),
    .in_data   ({sample_left, sample_right}),
    .in_ready  (sample_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (take)
  );

  // ==========================================================================
  // helpers
  // ==========================================================================
  // clamp a wide signed value to the sample range
  function automatic logic [SAMPLE_W-1:0] sat(input logic signed [39:0] v);
    logic signed [39:0] hi;
    logic signed [39:0] lo;
    hi = 40'sd1 <<< (SAMPLE_W - 1);
    lo = -hi;
    hi = hi - 40'sd1;
    if (v > hi) begin
      sat = hi[SAMPLE_W-1:0];
    end else if (v < lo) begin
      sat = lo[SAMPLE_W-1:0];
    end else begin
      sat = v[SAMPLE_W-1:0];
    end
  endfunction

  // volume code to ramp level, four levels per 0.5 dB code
  function automatic logic [10:0] code_level(input logic [7:0] code);
    if (code == playback_pkg::VOLUME_MUTE) begin
      code_level = playback_pkg::LEVEL_MUTE;
    end else begin
      code_level = {1'b0, code, 2'b00} >> (2 - playback_pkg::LEVEL_PER_CODE);
    end
  endfunction

  // ramp level to linear gain in Q15; level 0 reads as 1.0 and means +12 dB
  function automatic logic [16:0] gain_of(input logic [10:0] lvl);
    logic [10:0] oct;
    logic [10:0] rem;
    logic [31:0] prod;
    oct  = lvl / playback_pkg::LEVELS_PER_OCT;
    rem  = lvl - 11'(oct * playback_pkg::LEVELS_PER_OCT);
    prod = 32'(playback_pkg::GAIN_COARSE[rem[5:3]]) * 32'(playback_pkg::GAIN_FINE[rem[2:0]]);
    prod = (prod >> playback_pkg::GAIN_FRAC) >> oct;
    if (lvl >= playback_pkg::LEVEL_MUTE) begin
      gain_of = '0;
    end else begin
      gain_of = prod[16:0];
    end
  endfunction

  // move a level toward its target by at most one step, never past it
  function automatic logic [10:0] step_to(input logic [10:0] now, input logic [10:0] tgt,
                                          input logic [10:0] step);
    if (now < tgt) begin
      step_to = (tgt - now > step) ? now + step : tgt;
    end else if (now > tgt) begin
      step_to = (now - tgt > step) ? now - step : tgt;
    end else begin
      step_to = now;
    end
  endfunction

  // ==========================================================================
  // ramp targets
  // ==========================================================================
  // mute overrides both codes; releasing it simply restores the code target,
  // so a half-finished mute turns round from wherever the level stands
  always_comb begin
    if (cur.soft_mute_request) begin
      target[0] = playback_pkg::LEVEL_MUTE;
      target[1] = playback_pkg::LEVEL_MUTE;
    end else begin
      target[1] = code_level(cur.left_volume_code);
      target[0] = cur.volume_gang ? code_level(cur.left_volume_code)
                                  : code_level(cur.right_volume_code);
    end
    busy = (cur.level[0] != target[0]) || (cur.level[1] != target[1]);
  end

  // a pair leaves the fifo only when the output holder is free or draining
  assign take = fifo_valid & (~cur.dac_valid | dac_ready);

  // ==========================================================================
  // register port, filters, volume and output holder
  // ==========================================================================
  always_comb begin
    logic signed [SAMPLE_W-1:0] x;
    logic signed [39:0]         acc;
    logic signed [SAMPLE_W-1:0] y;
    logic signed [SAMPLE_W-1:0] lpv;
    logic signed [39:0]         bst;
    logic signed [SAMPLE_W-1:0] z;
    logic signed [39:0]         vol;
    logic [10:0]                step;
    x    = '0;
    acc  = '0;
    y    = '0;
    lpv  = '0;
    bst  = '0;
    z    = '0;
    vol  = '0;
    step = cur.ramp_time_select ? playback_pkg::STEP_FAST : playback_pkg::STEP_SLOW;
    next_cur = cur;

    // register writes take effect on the next sample that is processed
    if (reg_write) begin
      case (reg_addr)
        playback_pkg::ADDR_CTRL: begin
          next_cur.deemph_select     = reg_wdata[playback_pkg::CTRL_DEEMPH_LSB +: 2];
          next_cur.boost_select      = reg_wdata[playback_pkg::CTRL_BOOST_LSB +: 2];
          next_cur.volume_gang       = reg_wdata[playback_pkg::CTRL_GANG_BIT];
          next_cur.ramp_time_select  = reg_wdata[playback_pkg::CTRL_RAMP_BIT];
          next_cur.soft_mute_request = reg_wdata[playback_pkg::CTRL_SOFT_MUTE_REQUEST_BIT];
        end
        playback_pkg::ADDR_LEFT:  next_cur.left_volume_code  = reg_wdata;
        playback_pkg::ADDR_RIGHT: next_cur.right_volume_code = reg_wdata;
        default: ;  // writes elsewhere are dropped
      endcase
    end

    // read data stand for exactly one cycle, zero otherwise
    next_cur.rd_data = '0;
    if (reg_read) begin
      case (reg_addr)
        playback_pkg::ADDR_CTRL: begin
          next_cur.rd_data[playback_pkg::CTRL_DEEMPH_LSB +: 2] = cur.deemph_select;
          next_cur.rd_data[playback_pkg::CTRL_BOOST_LSB +: 2]  = cur.boost_select;
          next_cur.rd_data[playback_pkg::CTRL_GANG_BIT]        = cur.volume_gang;
          next_cur.rd_data[playback_pkg::CTRL_RAMP_BIT]        = cur.ramp_time_select;
          next_cur.rd_data[playback_pkg::CTRL_SOFT_MUTE_REQUEST_BIT]       = cur.soft_mute_request;
        end
        playback_pkg::ADDR_LEFT:  next_cur.rd_data = cur.left_volume_code;
        playback_pkg::ADDR_RIGHT: next_cur.rd_data = cur.right_volume_code;
        playback_pkg::ADDR_STATUS: begin
          next_cur.rd_data[playback_pkg::STAT_BUSY_BIT]  = busy;
          next_cur.rd_data[playback_pkg::STAT_MUTED_BIT] =
            (cur.level[0] == playback_pkg::LEVEL_MUTE) && (cur.level[1] == playback_pkg::LEVEL_MUTE);
        end
        default: next_cur.rd_data = '0;  // unmapped reads answer zero
      endcase
    end

    // output holder empties once the DAC has taken it
    if (cur.dac_valid && dac_ready) begin
      next_cur.dac_valid = 1'b0;
    end

    // one stereo pair per sample period; ramp advances with it
    if (take) begin
      for (int ch = 0; ch < 2; ch++) begin
        x = $signed(fifo_data[ch*SAMPLE_W +: SAMPLE_W]);
        // de-emphasis shelf: y = b0*x + b1*x1 + a1*y1, off passes x through
        acc = 40'($signed(x) * $signed(playback_pkg::DEEMPH_B0[cur.deemph_select]))
            + 40'($signed(cur.x1[ch]) * $signed(playback_pkg::DEEMPH_B1[cur.deemph_select]))
            + 40'($signed(cur.y1[ch]) * $signed(playback_pkg::DEEMPH_A1[cur.deemph_select]));
        y = $signed(sat(acc >>> playback_pkg::COEF_FRAC));
        next_cur.x1[ch] = x;
        next_cur.y1[ch] = y;
        // bass boost adds a scaled low-pass copy of the signal
        lpv = $signed(cur.lp[ch]);
        next_cur.lp[ch] = sat(40'(lpv) + ((40'(y) - 40'(lpv)) >>> playback_pkg::BOOST_SHIFT));
        case (cur.boost_select)
          playback_pkg::BOOST_OFF: bst = 40'(y);
          playback_pkg::BOOST_MIN: bst = 40'(y) + (40'(lpv) >>> 1);
          playback_pkg::BOOST_MID: bst = 40'(y) + 40'(lpv);
          playback_pkg::BOOST_MAX: bst = 40'(y) + (40'(lpv) <<< 1);
          default:                 bst = 40'(y);
        endcase
        // clip, never wrap, when the boost pushes past full scale
        z = $signed(sat(bst));
        // volume from the present ramp level, applied ahead of the DAC
        vol = 40'($signed(z) * $signed({1'b0, gain_of(cur.level[ch])}));
        next_cur.dac[ch] = sat(vol >>> playback_pkg::VOL_SHIFT);
        next_cur.level[ch] = step_to(cur.level[ch], target[ch], step);
      end
      next_cur.dac_valid = 1'b1;
    end
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  // level starts at the 0 dB code so there is no ramp at power-up
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
      cur.deemph_select     <= playback_pkg::DEEMPH_RESET;
      cur.boost_select      <= playback_pkg::BOOST_RESET;
      cur.left_volume_code  <= playback_pkg::VOLUME_RESET;
      cur.right_volume_code <= playback_pkg::VOLUME_RESET;
      cur.level[0]          <= 11'({playback_pkg::VOLUME_RESET, 2'b00});
      cur.level[1]          <= 11'({playback_pkg::VOLUME_RESET, 2'b00});
    end else begin
      cur <= next_cur;
    end
  end

  // outputs come straight from the state register
  assign reg_rdata = cur.rd_data;
  assign dac_valid = cur.dac_valid;
  assign dac_left  = cur.dac[1];
  assign dac_right = cur.dac[0];

endmodule

// File: playback_volume_asserts.sv
// checker on the ports of the playback volume block
`timescale 1ns/100ps
module playback_volume_asserts #(
  parameter int SAMPLE_W   = 16,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic                              sys_clk,
  input wire logic                              reset_n,
  input wire logic [playback_pkg::ADDR_W-1:0]   reg_addr,
  input wire logic [7:0]                        reg_wdata,
  input wire logic                              reg_write,
  input wire logic                              reg_read,
  input wire logic [7:0]                        reg_rdata,
  input wire logic                              sample_valid,
  input wire logic [SAMPLE_W-1:0]               sample_left,
  input wire logic [SAMPLE_W-1:0]               sample_right,
  input wire logic                              sample_ready,
  input wire logic                              dac_valid,
  input wire logic [SAMPLE_W-1:0]               dac_left,
  input wire logic [SAMPLE_W-1:0]               dac_right,
  input wire logic                              dac_ready
);
  // one clock domain, so one default clock and reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // register port
  // ==========================================================================
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  unmapped_zero_a: assert property ($past(reg_read) && $past(reg_addr) > playback_pkg::ADDR_STATUS
    |-> reg_rdata == 8'h00) else $error("unmapped read gave nonzero data");
  ctrl_top_a: assert property ($past(reg_read) && $past(reg_addr) == playback_pkg::ADDR_CTRL
    |-> !reg_rdata[7]) else $error("control bit 7 read as one");
  status_top_a: assert property ($past(reg_read) && $past(reg_addr) == playback_pkg::ADDR_STATUS
    |-> reg_rdata[7:2] == 6'h00) else $error("status upper bits not zero");

  // ==========================================================================
  // sample stream: a stalled pair must stand, a fresh pair must come out soon
  // ==========================================================================
  sequence offered;
    dac_valid && !dac_ready;
  endsequence
  sequence fresh_pair;
    sample_valid && sample_ready && !dac_valid;
  endsequence
  valid_hold_a: assert property (offered |=> dac_valid)
    else $error("output pair withdrawn before taken");
  data_hold_a: assert property (offered |=> $stable(dac_left) && $stable(dac_right))
    else $error("output pair changed while stalled");
  pair_latency_a: assert property (fresh_pair |-> ##[1:3] dac_valid)
    else $error("accepted pair did not reach the output");
  full_hold_a: assert property (!sample_ready && !dac_ready |=> !sample_ready)
    else $error("full buffer accepted space without a drain");
endmodule

bind playback_volume playback_volume_asserts #(.SAMPLE_W(SAMPLE_W), .FIFO_DEPTH(FIFO_DEPTH)) asserts_i (
  .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
  .sample_left(sample_left), .sample_right(sample_right), .sample_ready(sample_ready),
  .dac_valid(dac_valid), .dac_left(dac_left), .dac_right(dac_right), .dac_ready(dac_ready));

// File: dac_sink.sv
// model of the converter that takes processed pairs from the block
`timescale 1ns/100ps
module dac_sink (
  input  wire logic        sys_clk,
  input  wire logic        stall,      // hold ready low so the buffer backs up
  input  wire logic        dac_valid,
  input  wire logic [15:0] dac_left,
  input  wire logic [15:0] dac_right,
  output logic             dac_ready
);
  int          taken = 0;              // pairs received so far
  logic [15:0] last_left  = 16'h0000;  // most recent pair, for the bench
  logic [15:0] last_right = 16'h0000;
  initial dac_ready = 1'b0;
  // take a pair at an edge where both sides agree, ready follows the stall
  always @(posedge sys_clk) begin
    if (dac_valid === 1'b1 && dac_ready === 1'b1) begin
      last_left  <= dac_left;
      last_right <= dac_right;
      taken      <= taken + 1;
    end
    dac_ready <= !stall;
  end
endmodule

// File: tb_top.sv
// register and sample stream tests of the playback volume block
`timescale 1ns/100ps
module tb_top;
  logic        sys_clk = 1'b0, reset_n = 1'b0, stall = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, d;
  logic        reg_write = 1'b0, reg_read = 1'b0;
  logic        sample_valid = 1'b0, sample_ready, dac_valid, dac_ready;
  logic [15:0] sample_left = 16'h0000, sample_right = 16'h0000, dac_left, dac_right;
  int          failures = 0, n_compared = 0, cycles = 0, sent = 0, i;
  logic [3:0]  ra [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hA};  // reset read table
  int          rx [5] = '{1, 'h18, 'h18, 0, 0};

  playback_volume playback_volume_i (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample_left(sample_left), .sample_right(sample_right),
    .sample_ready(sample_ready), .dac_valid(dac_valid), .dac_left(dac_left),
    .dac_right(dac_right), .dac_ready(dac_ready));
  dac_sink sink_i (.sys_clk(sys_clk), .stall(stall), .dac_valid(dac_valid), .dac_left(dac_left),
    .dac_right(dac_right), .dac_ready(dac_ready));

  // ==========================================================================
  // clock, hang guard and verdict
  // ==========================================================================
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      close_out();
    end
  end
  task automatic close_out;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // compare with a tolerance, since gains are fixed point approximations
  task automatic check(input logic [15:0] seen, input int exp, input int tol);
    int s;
    s = $signed(seen);
    n_compared++;
    if ((^seen === 1'bx) || s - exp > tol || exp - s > tol) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, 16'(exp));
    end
  endtask

  // ==========================================================================
  // register port and sample stream drivers
  // ==========================================================================
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
  endtask
  // stream pairs, optionally alternating sign, then wait for the sink
  task automatic feed(input int n, input int v, input bit alt);
    @(posedge sys_clk);
    for (int k = 0; k < n; k++) begin
      sample_valid <= 1'b1;
      sample_left  <= 16'((alt && k[0]) ? -v : v);
      sample_right <= 16'((alt && k[0]) ? -v : v);
      do @(posedge sys_clk); while (sample_ready !== 1'b1);
      sent++;
    end
    sample_valid <= 1'b0;
    for (int k = 0; k < 100 && sink_i.taken != sent; k++) @(posedge sys_clk);
  endtask
  // high band gain of the shelf, from the coefficient set
  function automatic int nyq(input int c);
    return 10000 * ($signed(playback_pkg::DEEMPH_B0[c]) - $signed(playback_pkg::DEEMPH_B1[c]))
      / ((1 << playback_pkg::COEF_FRAC) + $signed(playback_pkg::DEEMPH_A1[c]));
  endfunction
  task automatic stat(input int exp);
    rd(playback_pkg::ADDR_STATUS, d);
    check({8'h00, d}, exp, 0);
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    wr(playback_pkg::ADDR_STATUS, 8'hFF);
    wr(4'hA, 8'h55);
    for (i = 0; i < 5; i++) begin
      rd(ra[i], d);
      check({8'h00, d}, rx[i], 0);
    end
    // stalled sink: buffer of 32 plus the held pair, then nothing lost
    stall <= 1'b1;
    feed(33, 100, 0);
    check({15'h0000, sample_ready}, 0, 0);
    stall <= 1'b0;
    feed(1, 8000, 0);
    check(16'(sink_i.taken), sent, 0);
    check(sink_i.last_left, 8000, 2);
    // every de-emphasis code on an alternating input
    for (i = 0; i < 4; i++) begin
      wr(playback_pkg::ADDR_CTRL, 8'(i));
      feed(200, 10000, 1);
      check(sink_i.last_left, -nyq(i), 300);
    end
    // every boost code on a steady input, the top one saturates
    for (i = 0; i < 4; i++) begin
      wr(playback_pkg::ADDR_CTRL, 8'(i * 4 + 1));
      feed(800, 12000, 0);
      check(sink_i.last_left, (i == 3) ? 32767 : 12000 + 6000 * i, 200);
    end
    // separate channels, then ganged
    wr(playback_pkg::ADDR_CTRL, 8'h01);
    wr(playback_pkg::ADDR_RIGHT, 8'h30);
    feed(300, 8000, 0);
    check(sink_i.last_left, 8000, 3);
    check(sink_i.last_right, 2000, 3);
    wr(playback_pkg::ADDR_CTRL, 8'h11);
    feed(120, 8000, 0);
    check(sink_i.last_right, 8000, 3);
    // slow ramp over the full range
    wr(playback_pkg::ADDR_LEFT, 8'h00);
    rd(playback_pkg::ADDR_LEFT, d);
    check({8'h00, d}, 0, 0);
    feed(100, 8000, 0);
    check(sink_i.last_left, 32000, 300);
    feed(2, 12000, 0);
    check(sink_i.last_left, 32767, 0);
    wr(playback_pkg::ADDR_LEFT, 8'hFF);
    feed(1060, 8000, 0);
    stat(1);
    feed(1, 8000, 0);
    stat(2);
    check(sink_i.last_right, 0, 1);
    // fast ramp back over the full range
    wr(playback_pkg::ADDR_CTRL, 8'h31);
    wr(playback_pkg::ADDR_LEFT, 8'h00);
    feed(265, 8000, 0);
    stat(1);
    feed(1, 8000, 0);
    stat(0);
    // soft mute down and up
    wr(playback_pkg::ADDR_LEFT, 8'h18);
    feed(30, 8000, 0);
    wr(playback_pkg::ADDR_CTRL, 8'h71);
    feed(241, 8000, 0);
    stat(1);
    feed(1, 8000, 0);
    stat(2);
    check(sink_i.last_left, 0, 1);
    wr(playback_pkg::ADDR_CTRL, 8'h31);
    feed(244, 8000, 0);
    stat(0);
    check(sink_i.last_left, 8000, 3);
    // release in mid ramp returns from the level reached
    wr(playback_pkg::ADDR_CTRL, 8'h71);
    feed(100, 8000, 0);
    check(sink_i.last_left, 25, 4);
    wr(playback_pkg::ADDR_CTRL, 8'h31);
    feed(100, 8000, 0);
    stat(0);
    feed(2, 8000, 0);
    check(sink_i.last_left, 8000, 3);
    close_out();
  end
endmodule
